/* File: inc/zone_guard_map.svh */
`ifndef ZONE_GUARD_MAP_SVH
`define ZONE_GUARD_MAP_SVH
// Register word indexes on the control bus
`define ZG_REG_KEY0 4'h0
`define ZG_REG_KEY1 4'h1
`define ZG_REG_KEY2 4'h2
`define ZG_REG_KEY3 4'h3
`define ZG_REG_ZONE_SEL 4'h4
`define ZG_REG_RAM_CLAIM 4'h5
`define ZG_REG_SECT_CLAIM 4'h6
`define ZG_REG_STATUS 4'h7
`define ZG_REG_PWD_LOAD 4'h8
// Field layout
`define ZG_NUM_ZONES 3
`define ZG_NUM_RAM 8
`define ZG_NUM_SECT 16
`define ZG_SECT_N 4'hF
`define ZG_SECT_A 4'h0
`define ZG_ZONE_M1 2'h0
`define ZG_ZONE_M2 2'h1
`define ZG_ZONE_C 2'h2
// Reset values
`define ZG_RAM_CLAIM_RST 16'h0000
`define ZG_SECT_CLAIM_RST 32'h0000_0000
`define ZG_PWD_ONES 128'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF
`define ZG_PWD_ZERO 128'h0
`endif

/* File: inc/zone_guard_pkg.sv */
package zone_guard_pkg;
   // Requester that issued a memory access
   typedef enum logic {src_cpu, src_debug} src_type;
   // Memory region kind
   typedef enum logic [1:0] {reg_open, reg_ram, reg_sect} region_type;
   // Bus slave sequencing
   typedef enum logic [1:0] {bus_idle, bus_ack, bus_done} bus_state_type;
endpackage

/* File: hdl/zone_guard.sv */
// Overview of operation
// - Blocked reads return zero, no stall.
// - Locked, secure PC: block debug only.
// - Locked, unsecure PC: block everything.
// - Judge each access by current PC.
// - Each zone owns a 128-bit password.
// - Password lives in zone's own sector.
// - Matching keys unlock the zone.
// - All-ones password means unlocked.
// - Reading erased password alone unlocks.
// - All-zero password keeps zone locked.
// - Zero password after reset never unlocks.
// - Two master zones, one control zone.
// - Claim registers map RAM and sectors.
// - Sector N zone one, A zone two.
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "zone_guard_map.svh"

module zone_guard
(
   input wire logic clk,
   input wire logic rst,
   // Avalon-MM control slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Access request from CPU or debug path
   input wire logic acc_valid,
   input wire logic acc_debug,
   input wire logic acc_write,
   input wire logic [1:0] acc_zone_space,
   input wire logic acc_ram,
   input wire logic [3:0] acc_block,
   input wire logic acc_pc_secure,
   input wire logic [31:0] acc_wdata,
   // Memory side
   input wire logic [31:0] mem_rdata,
   output logic mem_we_ff,
   output logic [31:0] mem_wdata_ff,
   output logic acc_done_ff,
   output logic [31:0] acc_rdata_ff,
   output logic acc_blocked_ff,
   // Password word read from the zone's flash sector
   input wire logic pwd_valid,
   input wire logic [1:0] pwd_zone,
   input wire logic [1:0] pwd_word,
   input wire logic [31:0] pwd_data,
   output logic [2:0] zone_unlocked_ff
);

   // ****************************************
   // Storage
   // ****************************************
   logic [127:0] pwd_ff [0:2];
   logic [2:0] pwd_seen_ff;
   logic [127:0] key_ff [0:2];
   logic [1:0] zone_sel_ff;
   logic [15:0] ram_claim_ff;
   logic [31:0] sect_claim_ff;
   zone_guard_pkg::bus_state_type bus_state_ff;
   logic [31:0] rd_mux;
   logic [1:0] owner;
   logic blocked;
   logic [1:0] z;

   // Zone that owns a master-subsystem sector, sector N and A fixed
   function automatic logic [1:0] sect_owner(input logic [3:0] s, input logic [31:0] claim);
      logic [1:0] f;
      f = claim[{s, 1'b0} +: 2];
      if (s == `ZG_SECT_N)
         sect_owner = `ZG_ZONE_M1;
      else if (s == `ZG_SECT_A)
         sect_owner = `ZG_ZONE_M2;
      else
         sect_owner = f;
   endfunction

   // Two-bit claim field, 2'h3 means not secure
   function automatic logic [1:0] ram_owner(input logic [2:0] r, input logic [15:0] claim);
      ram_owner = claim[{r, 1'b0} +: 2];
   endfunction

   // ****************************************
   // Access judgement
   // ****************************************
   // Ownership and lock checked fresh on every access from live PC
   always_comb
   begin
      z = 2'h3;
      if (acc_zone_space == 2'h3)
         z = 2'h3; // Open space belongs to no zone
      else if (acc_zone_space == `ZG_ZONE_C)
         z = `ZG_ZONE_C;
      else if (acc_ram)
         z = ram_owner(acc_block[2:0], ram_claim_ff);
      else
         z = sect_owner(acc_block, sect_claim_ff);
      owner = z;
      blocked = 1'b0;
      if (owner != 2'h3 && !zone_unlocked_ff[owner])
      begin
         if (!acc_pc_secure)
            blocked = 1'b1;
         else
            blocked = acc_debug;
      end
   end

   // Single-cycle answer so the requester never stalls
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         acc_done_ff <= 1'b0;
         acc_rdata_ff <= 32'h0000_0000;
         acc_blocked_ff <= 1'b0;
         mem_we_ff <= 1'b0;
         mem_wdata_ff <= 32'h0000_0000;
      end
      else
      begin
         acc_done_ff <= acc_valid;
         acc_blocked_ff <= acc_valid & blocked;
         acc_rdata_ff <= (acc_valid && !acc_write && !blocked) ? mem_rdata : 32'h0000_0000;
         mem_we_ff <= acc_valid & acc_write & ~blocked;
         mem_wdata_ff <= acc_wdata;
      end
   end

   // ****************************************
   // Password capture and lock state
   // ****************************************
   // Password words come only from each zone's dedicated sector reads
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pwd_seen_ff <= 3'h0;
         for (int i = 0; i < 3; i++)
            pwd_ff[i] <= `ZG_PWD_ZERO;
      end
      else if (pwd_valid && pwd_zone != 2'h3)
      begin
         pwd_ff[pwd_zone][{pwd_word, 5'h00} +: 32] <= pwd_data;
         if (pwd_word == 2'h3)
            pwd_seen_ff[pwd_zone] <= 1'b1;
      end
   end

   // Locked at reset; erased password unlocks on read, zero never does
   always_ff @(posedge clk)
   begin
      if (rst)
         zone_unlocked_ff <= 3'h0;
      else
         for (int i = 0; i < 3; i++)
         begin
            if (!pwd_seen_ff[i] || pwd_ff[i] == `ZG_PWD_ZERO)
               zone_unlocked_ff[i] <= 1'b0;
            else if (pwd_ff[i] == `ZG_PWD_ONES)
               zone_unlocked_ff[i] <= 1'b1;
            else if (key_ff[i] == pwd_ff[i])
               zone_unlocked_ff[i] <= 1'b1;
            else
               zone_unlocked_ff[i] <= 1'b0;
         end
   end

   // ****************************************
   // Control registers
   // ****************************************
   // Keys are written into the selected zone; a key change relocks on mismatch
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         zone_sel_ff <= `ZG_ZONE_M1;
         ram_claim_ff <= `ZG_RAM_CLAIM_RST;
         sect_claim_ff <= `ZG_SECT_CLAIM_RST;
         for (int i = 0; i < 3; i++)
            key_ff[i] <= `ZG_PWD_ONES;
      end
      else if (avs_write && bus_state_ff == zone_guard_pkg::bus_ack) // Lands on the edge that sees waitrequest low
      begin
         case (avs_address)
            `ZG_REG_KEY0, `ZG_REG_KEY1, `ZG_REG_KEY2, `ZG_REG_KEY3:
               if (zone_sel_ff != 2'h3)
                  key_ff[zone_sel_ff][{avs_address[1:0], 5'h00} +: 32] <= avs_writedata;
            `ZG_REG_ZONE_SEL: zone_sel_ff <= avs_writedata[1:0];
            `ZG_REG_RAM_CLAIM: ram_claim_ff <= avs_writedata[15:0];
            `ZG_REG_SECT_CLAIM: sect_claim_ff <= avs_writedata;
            default: ;
         endcase
      end
   end

   // Read mux; key registers read back zero to avoid leaking the key
   always_comb
   begin
      case (avs_address)
         `ZG_REG_ZONE_SEL: rd_mux = {30'h0, zone_sel_ff};
         `ZG_REG_RAM_CLAIM: rd_mux = {16'h0, ram_claim_ff};
         `ZG_REG_SECT_CLAIM: rd_mux = sect_claim_ff;
         `ZG_REG_STATUS: rd_mux = {26'h0, pwd_seen_ff, zone_unlocked_ff};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Two-step slave: waitrequest drops one cycle after the request
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bus_state_ff <= zone_guard_pkg::bus_idle;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end
      else
         case (bus_state_ff)
            zone_guard_pkg::bus_idle:
               if (avs_read || avs_write)
               begin
                  bus_state_ff <= zone_guard_pkg::bus_ack;
                  avs_waitrequest <= 1'b0;
                  avs_readdata <= rd_mux;
               end
            zone_guard_pkg::bus_ack:
            begin
               bus_state_ff <= zone_guard_pkg::bus_idle;
               avs_waitrequest <= 1'b1;
            end
            default:
            begin
               bus_state_ff <= zone_guard_pkg::bus_idle;
               avs_waitrequest <= 1'b1;
            end
         endcase
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_block_read;
      @(posedge clk) disable iff (rst)
      (acc_valid && !acc_write && blocked) |=> (acc_rdata_ff == 32'h0000_0000 && acc_done_ff);
   endproperty
   a_block_read: assert property (p_block_read) else $error("blocked read not zero");

   property p_debug_only;
      @(posedge clk) disable iff (rst)
      (acc_valid && acc_pc_secure && !acc_debug) |=> !acc_blocked_ff;
   endproperty
   a_debug_only: assert property (p_debug_only) else $error("secure cpu access blocked");

   property p_unsecure_pc;
      @(posedge clk) disable iff (rst)
      (acc_valid && !acc_pc_secure && owner != 2'h3 && !zone_unlocked_ff[owner]) |=> acc_blocked_ff;
   endproperty
   a_unsecure_pc: assert property (p_unsecure_pc) else $error("locked access passed");

   property p_write_drop;
      @(posedge clk) disable iff (rst)
      (acc_valid && acc_write && blocked) |=> !mem_we_ff;
   endproperty
   a_write_drop: assert property (p_write_drop) else $error("blocked write reached memory");

   property p_zero_locked;
      @(posedge clk) disable iff (rst)
      (pwd_ff[0] == `ZG_PWD_ZERO) |=> !zone_unlocked_ff[0];
   endproperty
   a_zero_locked: assert property (p_zero_locked) else $error("zero password unlocked");

   property p_ones_open;
      @(posedge clk) disable iff (rst)
      (pwd_seen_ff[0] && pwd_ff[0] == `ZG_PWD_ONES) |=> zone_unlocked_ff[0];
   endproperty
   a_ones_open: assert property (p_ones_open) else $error("erased zone still locked");

   property p_sect_fixed;
      @(posedge clk) disable iff (rst)
      (acc_valid && !acc_ram && acc_zone_space[1] == 1'b0 && acc_block == `ZG_SECT_N) |-> owner == `ZG_ZONE_M1;
   endproperty
   a_sect_fixed: assert property (p_sect_fixed) else $error("sector N not zone one");

   property p_bus_ack;
      @(posedge clk) disable iff (rst)
      ($rose(avs_read) && bus_state_ff == zone_guard_pkg::bus_idle) |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("bus answer late");

   property p_done_pulse;
      @(posedge clk) disable iff (rst)
      acc_valid |=> acc_done_ff;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("access answer missing");

   property p_write_no_stall;
      @(posedge clk) disable iff (rst)
      (acc_valid && acc_write && blocked) |=> (acc_done_ff && acc_blocked_ff);
   endproperty
   a_write_no_stall: assert property (p_write_no_stall) else $error("blocked write stalled");

   property p_debug_write;
      @(posedge clk) disable iff (rst)
      (acc_valid && acc_write && acc_debug && owner != 2'h3 && !zone_unlocked_ff[owner]) |=> !mem_we_ff;
   endproperty
   a_debug_write: assert property (p_debug_write) else $error("debug write to locked zone");

   property p_key_match;
      @(posedge clk) disable iff (rst)
      (pwd_seen_ff[1] && pwd_ff[1] != `ZG_PWD_ZERO && key_ff[1] == pwd_ff[1]) |=> zone_unlocked_ff[1];
   endproperty
   a_key_match: assert property (p_key_match) else $error("matching keys left zone locked");

   property p_key_mismatch;
      @(posedge clk) disable iff (rst)
      (pwd_ff[1] != `ZG_PWD_ONES && key_ff[1] != pwd_ff[1]) |=> !zone_unlocked_ff[1];
   endproperty
   a_key_mismatch: assert property (p_key_mismatch) else $error("wrong keys unlocked zone");

   property p_unseen_locked;
      @(posedge clk) disable iff (rst)
      !pwd_seen_ff[2] |=> !zone_unlocked_ff[2];
   endproperty
   a_unseen_locked: assert property (p_unseen_locked) else $error("unread password unlocked");

   property p_ctrl_zero;
      @(posedge clk) disable iff (rst)
      (pwd_seen_ff[2] && pwd_ff[2] == `ZG_PWD_ZERO) |=> !zone_unlocked_ff[2];
   endproperty
   a_ctrl_zero: assert property (p_ctrl_zero) else $error("zero password zone opened");

   property p_sect_a;
      @(posedge clk) disable iff (rst)
      (acc_valid && !acc_ram && acc_zone_space[1] == 1'b0 && acc_block == `ZG_SECT_A) |-> owner == `ZG_ZONE_M2;
   endproperty
   a_sect_a: assert property (p_sect_a) else $error("sector A not zone two");

   property p_ctrl_space;
      @(posedge clk) disable iff (rst)
      (acc_valid && acc_zone_space == `ZG_ZONE_C) |-> owner == `ZG_ZONE_C;
   endproperty
   a_ctrl_space: assert property (p_ctrl_space) else $error("control space not control zone");

endmodule
`default_nettype wire

/* File: tb/mem_partner.sv */
`timescale 1ns/10ps
`default_nettype none
// **********************************
// Memory behind the guard
// **********************************
module mem_partner
(
   input wire logic clk,
   input wire logic valid,
   input wire logic [6:0] idx,
   input wire logic we,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata
);
   logic [31:0] mem [128];
   logic [6:0] idx_ff;
   // Seed pattern that the bench mirrors
   initial
      for (int i = 0; i < 128; i++)
         mem[i] = 32'hA500_0000 | i;
   // Garbage outside an access, so a stale read never looks right
   assign rdata = valid ? mem[idx] : ~mem[idx];
   // Write lands one cycle after the request, at the address it named
   always @(posedge clk)
   begin
      idx_ff <= idx;
      if (we)
         mem[idx_ff] <= wdata;
   end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "zone_guard_map.svh"
// **********************************
// Guard bench
// **********************************
module tb;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [3:0] avs_address = 4'h0, acc_block = 4'h0;
   logic avs_read = 1'h0, avs_write = 1'h0, acc_valid = 1'h0, acc_debug = 1'h0;
   logic acc_write = 1'h0, acc_ram = 1'h0, acc_pc_secure = 1'h0, pwd_valid = 1'h0;
   logic [31:0] avs_writedata = 32'h0, acc_wdata = 32'h0, pwd_data = 32'h0;
   logic [31:0] mem_rdata, avs_readdata, mem_wdata_ff, acc_rdata_ff, q;
   logic [1:0] acc_zone_space = 2'h0, pwd_zone = 2'h0, pwd_word = 2'h0;
   logic avs_waitrequest, mem_we_ff, acc_done_ff, acc_blocked_ff;
   logic [2:0] zone_unlocked_ff, exp_unl = 3'h0;
   logic [15:0] ram_clm = 16'h0;
   logic [31:0] sect_clm = 32'h0;
   logic [127:0] pwd;
   logic [31:0] exp_mem [128];
   int seed = 48788, num_errors = 0, tests_run = 0;

   zone_guard uut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .acc_valid, .acc_debug, .acc_write, .acc_zone_space, .acc_ram, .acc_block,
      .acc_pc_secure, .acc_wdata, .mem_rdata, .mem_we_ff, .mem_wdata_ff, .acc_done_ff, .acc_rdata_ff,
      .acc_blocked_ff, .pwd_valid, .pwd_zone, .pwd_word, .pwd_data, .zone_unlocked_ff);
   mem_partner mdl (.clk(clk), .valid(acc_valid), .idx({acc_zone_space, acc_ram, acc_block}),
      .we(mem_we_ff), .wdata(mem_wdata_ff), .rdata(mem_rdata));

   // Clock and memory mirror
   initial
      forever #2 clk = ~clk;
   initial
      for (int i = 0; i < 128; i++)
         exp_mem[i] = 32'hA500_0000 | i;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Bus cycle; request held until the rising edge that sees waitrequest low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do
      begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'h0);
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask

   task automatic load_pwd(input logic [1:0] z, input logic [127:0] p);
      for (int w = 0; w < 4; w++)
      begin
         @(posedge clk);
         pwd_valid <= 1'h1;
         pwd_zone <= z;
         pwd_word <= w[1:0];
         pwd_data <= p[32*w+:32];
      end
      @(posedge clk);
      pwd_valid <= 1'h0;
   endtask

   task automatic set_keys(input logic [1:0] z, input logic [127:0] k);
      bus(1'h1, `ZG_REG_ZONE_SEL, {30'h0, z});
      for (int w = 0; w < 4; w++)
         bus(1'h1, `ZG_REG_KEY0 + w[3:0], k[32*w+:32]);
   endtask

   task automatic settle(input logic [2:0] e);
      repeat (2) @(posedge clk);
      #1;
      check(zone_unlocked_ff, e, "unlocked");
   endtask

   // Owning zone of an access; 3 means open
   function automatic logic [1:0] zone_of(input logic [6:0] ix);
      if (ix[6:5] == 2'h3)
         return 2'h3;
      if (ix[6:5] == 2'h2)
         return `ZG_ZONE_C;
      if (ix[4])
         return ram_clm[2*ix[2:0]+:2];
      if (ix[3:0] == `ZG_SECT_N)
         return `ZG_ZONE_M1;
      if (ix[3:0] == `ZG_SECT_A)
         return `ZG_ZONE_M2;
      return sect_clm[2*ix[3:0]+:2];
   endfunction

   // Random accesses, first two on the fixed sectors
   task automatic run_acc(input int n);
      logic [31:0] r, d;
      logic [6:0] ix;
      logic ok;
      for (int k = 0; k < n; k++)
      begin
         r = $random(seed);
         d = $random(seed);
         ix = {r[1:0], r[2], r[2] ? {1'h0, r[5:3]} : r[6:3]};
         if (k < 2)
            ix = {3'h0, k[0] ? `ZG_SECT_N : `ZG_SECT_A};
         ok = zone_of(ix) == 2'h3 || exp_unl[zone_of(ix)] || (r[9] && !r[7]);
         @(posedge clk);
         acc_valid <= 1'h1;
         acc_zone_space <= ix[6:5];
         acc_ram <= ix[4];
         acc_block <= ix[3:0];
         acc_debug <= r[7];
         acc_write <= r[8];
         acc_pc_secure <= r[9];
         acc_wdata <= d;
         @(posedge clk);
         acc_valid <= 1'h0;
         #1;
         check(acc_done_ff, 32'h1, "done");
         check(acc_blocked_ff, !ok, "blocked");
         check(mem_we_ff, ok && r[8], "mem_we");
         if (!r[8])
            check(acc_rdata_ff, ok ? exp_mem[ix] : 32'h0, "rdata");
         if (ok && r[8])
         begin
            check(mem_wdata_ff, d, "wdata");
            exp_mem[ix] = d;
         end
      end
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      #1;
      check(zone_unlocked_ff, 32'h0, "unlocked");
      run_acc(40);
      $display("test locked_access done");
      ram_clm = ($random(seed) & 16'h5555) | 16'hC000;
      sect_clm = $random(seed) & 32'h5555_5555;
      bus(1'h1, `ZG_REG_RAM_CLAIM, {16'h0, ram_clm});
      bus(1'h1, `ZG_REG_SECT_CLAIM, sect_clm);
      load_pwd(`ZG_ZONE_M1, `ZG_PWD_ONES);
      settle(3'h1);
      pwd = {$random(seed), $random(seed), $random(seed), $random(seed)};
      load_pwd(`ZG_ZONE_M2, pwd);
      settle(3'h1);
      set_keys(`ZG_ZONE_M2, pwd);
      settle(3'h3);
      bus(1'h0, `ZG_REG_KEY1, 32'h0);
      check(q, 32'h0, "key_read");
      bus(1'h1, `ZG_REG_KEY2, ~pwd[95:64]);
      settle(3'h1);
      exp_unl = 3'h1;
      run_acc(40);
      $display("test split_zones done");
      bus(1'h1, `ZG_REG_KEY2, pwd[95:64]);
      settle(3'h3);
      // Zero password is one software should avoid; used here on purpose
      load_pwd(`ZG_ZONE_C, `ZG_PWD_ZERO);
      set_keys(`ZG_ZONE_C, `ZG_PWD_ZERO);
      settle(3'h3);
      exp_unl = 3'h3;
      bus(1'h0, `ZG_REG_STATUS, 32'h0);
      check(q, 32'h3B, "status");
      bus(1'h0, 4'hF, 32'h0);
      check(q, 32'h0, "unmapped");
      $display("test passwords done");
      run_acc(60);
      $display("test claimed_access done");
      final_report;
   end

   // Hang guard
   initial
   begin
      repeat (5000) @(posedge clk);
      num_errors++;
      $display("watchdog expired");
      final_report;
   end
endmodule
`default_nettype wire
